// ---- rtl/clock_reset_pkg.sv ----
// package: constants, register map and carrier types for the clock and reset control block
package clock_reset_pkg;

   // timing: the system clock stands for four times the oscillator rate
   localparam int CLOCK_PERIOD_NS = 25;
   localparam int CLOCKS_PER_OSC = 4;
   // core period is 3/2 of an oscillator period (times 3, divided by 2)
   localparam int CORE_PERIOD_CLOCKS = CLOCKS_PER_OSC * 3 / 2;
   localparam int CORE_HALF_CLOCKS = CORE_PERIOD_CLOCKS / 2;
   // usb clock: oscillator rate in 6 MHz mode, half of it in 12 MHz mode
   localparam int USB_HALF_SLOW_OSC = CLOCKS_PER_OSC / 2;
   localparam int USB_HALF_FAST_OSC = CLOCKS_PER_OSC;
   localparam int STARTUP_CORE_CYCLES = 514;
   localparam int STARTUP_CLOCKS = STARTUP_CORE_CYCLES * CORE_PERIOD_CLOCKS;
   localparam int PIN_BLANK_CLOCKS = 3;

   // reset vector location, high byte first
   localparam logic [15:0] VECTOR_HIGH_ADDR = 16'hFFFE;
   localparam logic [15:0] VECTOR_LOW_ADDR = 16'hFFFF;

   // register offsets (byte addresses)
   localparam logic [7:0] MISC_OFFSET = 8'h00;
   localparam logic [7:0] OPTION_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;

   // field positions
   localparam int MISC_CLKOUT_BIT = 0;
   localparam int MISC_SLOW_LSB = 1;
   localparam int OPT_OSC_BIT = 0;
   localparam int OPT_UVD_BIT = 1;
   localparam int STAT_CORE_RESET_BIT = 0;
   localparam int STAT_LVD_BIT = 1;
   localparam int STAT_WDG_BIT = 2;
   localparam int STAT_PIN_BIT = 3;
   localparam int STAT_PIN_LEVEL_BIT = 4;

   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   // packed order puts the last member at bit 0, matching the field positions above
   typedef struct packed {
      logic [1:0] slowDividerSelect;
      logic clockOutEnable;
   } misc_type;

   typedef struct packed {
      logic undervoltageDetectorDisable;
      logic oscFreqSelect;
   } option_type;

   localparam misc_type MISC_RESET = '{clockOutEnable: 1'b0, slowDividerSelect: 2'h0};
   localparam option_type OPTION_RESET = '{oscFreqSelect: 1'b0,
      undervoltageDetectorDisable: 1'b0};

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef enum logic [2:0] {ST_HOLD, ST_WAIT, ST_FETCH_HI, ST_FETCH_LO, ST_RUN} seq_state_type;

endpackage

// ---- rtl/slow_clock_divider.sv ----
// slow-mode divider: divides the core clock by 1, 2, 4 or 8
`timescale 1ns/1ps
module slow_clock_divider (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic coreToggle,
   input wire logic [1:0] dividerSelect,
   output logic slowClock
);
   import clock_reset_pkg::*;

   logic [2:0] edgeCount_reg;
   logic [2:0] edgeCount_next;
   logic slowClock_next;
   logic [2:0] toggleLimit;
   logic atLimit;

   // a square wave divided by n toggles once every n input toggles
   assign toggleLimit = 3'((4'h1 << dividerSelect) - 4'h1); // [R4]
   assign atLimit = (edgeCount_reg >= toggleLimit);
   assign edgeCount_next = !coreToggle ? edgeCount_reg : (atLimit ? 3'h0 : edgeCount_reg + 3'h1);
   assign slowClock_next = (coreToggle && atLimit) ? !slowClock : slowClock; // [R4]

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         edgeCount_reg <= 3'h0;
         slowClock <= 1'b0;
      end else begin
         edgeCount_reg <= edgeCount_next;
         slowClock <= slowClock_next;
      end
   end
endmodule // slow_clock_divider

// ---- rtl/clock_divider_reset_control.sv ----
// clock generation and reset sequencing with an apb register slave
// Notes on behaviour
// R1 - core clock is oscillator times two over three
// R2 - 12 MHz option keeps 8 MHz core, 6 MHz usb
// R3 - core clock has equal high and low phases
// R4 - slow mode divides core clock by 1,2,4,8
// R5 - clock output enable drives core clock on B0
// R6 - three reset sources: low voltage, watchdog, pin
// R7 - after reset load pc from top two bytes
// R8 - wait 514 core cycles before starting execution
// R9 - low voltage reset drives reset pin low
// R10 - detector disable option ignores low voltage
// R11 - watchdog reset also pulls reset pin low
// R12 - external party holds pin low 1.5 cycles
// R13 - synchronised low pin level merges into reset
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module clock_divider_reset_control (
   input wire logic clock,
   input wire logic sys_rst,
   input clock_reset_pkg::apb_req_type apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic oscActive,
   input wire logic lowVoltage,
   input wire logic watchdogReset,
   input wire logic resetPinIn_n,
   output logic resetPinOut,
   output logic resetPinOe,
   output logic coreClock,
   output logic slowClock,
   output logic usbClock,
   output logic portB0Out,
   output logic portB0Oe,
   output logic coreReset,
   output logic [15:0] memAddr,
   output logic memRead,
   input wire logic [7:0] memData,
   output logic [15:0] pcValue,
   output logic pcLoad
);
   import clock_reset_pkg::*;

   localparam logic [1:0] CORE_LAST = 2'(CORE_HALF_CLOCKS - 1);
   localparam logic [2:0] USB_LAST_SLOW = 3'(USB_HALF_SLOW_OSC - 1);
   localparam logic [2:0] USB_LAST_FAST = 3'(USB_HALF_FAST_OSC - 1);
   localparam logic [11:0] WAIT_LAST = 12'(STARTUP_CLOCKS - 1);

   misc_type miscReg_reg;
   option_type optionReg_reg;
   logic [3:0] causeFlags_reg;
   seq_state_type state_reg, state_next;
   logic [11:0] waitCount_reg;
   logic [1:0] corePhase_reg;
   logic [2:0] usbPhase_reg;
   logic [7:0] vectorHigh_reg;
   logic lvdMeta_reg, lvdSync_reg, oscMeta_reg, oscSync_reg, pinMeta_reg, pinSync_reg;
   logic [PIN_BLANK_CLOCKS-1:0] driveHist_reg;
   logic watchdogHold_reg;

   // apb decode
   wire logic accessPhase = apbReq.psel && apbReq.penable;
   wire logic commit = accessPhase && pready;
   wire logic hitMisc = (apbReq.paddr == MISC_OFFSET);
   wire logic hitOption = (apbReq.paddr == OPTION_OFFSET);
   wire logic hitStatus = (apbReq.paddr == STATUS_OFFSET);
   wire logic mapped = hitMisc || hitOption || hitStatus;
   wire logic writeMisc = commit && apbReq.pwrite && hitMisc;
   wire logic writeOption = commit && apbReq.pwrite && hitOption;
   wire logic clearCause = commit && apbReq.pwrite && hitStatus;

   // reset sources, low voltage and pin qualified; the pin is blanked while we drive it and just after
   wire logic lvdActive = lvdSync_reg && !optionReg_reg.undervoltageDetectorDisable; // [R10]
   wire logic pinRequest = !pinSync_reg && !resetPinOe && !(|driveHist_reg); // [R13]
   wire logic watchdogActive = watchdogReset || watchdogHold_reg;
   // the watchdog hold only keeps the pin low and the watchdog cause flag set; letting it hold the sequencer too would
   // stop the start-up count that is what releases the hold
   wire logic anyReset = lvdActive || watchdogReset || pinRequest || !oscSync_reg; // [R6]
   wire logic driveNext = lvdActive || watchdogActive; // [R9] [R11]
   wire logic waitDone = (waitCount_reg == WAIT_LAST);

   // clock phase decode
   wire logic coreToggle = (corePhase_reg == CORE_LAST);
   wire logic [2:0] usbLast = optionReg_reg.oscFreqSelect ? USB_LAST_FAST : USB_LAST_SLOW; // [R2]
   wire logic usbToggle = (usbPhase_reg >= usbLast);

   // read data mux, reserved bits read zero
   // the pin level is reported from the synchroniser, never straight from the pad
   wire logic [31:0] statusWord = DATA_ZERO | (32'(pinSync_reg) << STAT_PIN_LEVEL_BIT)
      | (32'(causeFlags_reg) << STAT_LVD_BIT) | (32'(coreReset) << STAT_CORE_RESET_BIT);
   wire logic [31:0] readWord = hitMisc ? 32'(miscReg_reg) << MISC_CLKOUT_BIT :
      hitOption ? 32'(optionReg_reg) << OPT_OSC_BIT :
      hitStatus ? statusWord : DATA_ZERO;

   // cause flags: sticky, write one to clear, a new cause wins over the clear
   wire logic [3:0] causeSet = {1'b0, pinRequest, watchdogActive, lvdActive};
   wire logic [3:0] causeClear = clearCause ? 4'(apbReq.pwdata >> STAT_LVD_BIT) : 4'h0;
   wire logic [3:0] causeNext = (causeFlags_reg & ~causeClear) | causeSet;

   // start-up sequencer: hold, count the delay, fetch vector bytes, run
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_HOLD: state_next = ST_WAIT;
         ST_WAIT: if (waitDone) begin
            state_next = ST_FETCH_HI; // [R8]
         end
         ST_FETCH_HI: state_next = ST_FETCH_LO;
         ST_FETCH_LO: state_next = ST_RUN;
         ST_RUN: state_next = ST_RUN;
      endcase
      if (anyReset) begin
         state_next = ST_HOLD;
      end
   end

   // two-stage synchronisers for pins from outside the clock domain
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         {lvdMeta_reg, lvdSync_reg} <= 2'h0;
         {oscMeta_reg, oscSync_reg} <= 2'h0;
         {pinMeta_reg, pinSync_reg} <= 2'h3;
      end else begin
         {lvdMeta_reg, lvdSync_reg} <= {lowVoltage, lvdMeta_reg};
         {oscMeta_reg, oscSync_reg} <= {oscActive, oscMeta_reg};
         {pinMeta_reg, pinSync_reg} <= {resetPinIn_n, pinMeta_reg}; // [R13]
      end
   end

   // apb slave: one wait state, answer registered
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= DATA_ZERO;
      end else begin
         pready <= accessPhase && !pready;
         pslverr <= accessPhase && !pready && !mapped;
         prdata <= (accessPhase && !pready && !apbReq.pwrite) ? readWord : DATA_ZERO;
      end
   end

   // software registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         miscReg_reg <= MISC_RESET;
         optionReg_reg <= OPTION_RESET;
         causeFlags_reg <= 4'h0;
      end else begin
         if (writeMisc) begin
            miscReg_reg <= misc_type'(apbReq.pwdata[MISC_SLOW_LSB+1:MISC_CLKOUT_BIT]);
         end
         if (writeOption) begin
            optionReg_reg <= option_type'(apbReq.pwdata[OPT_UVD_BIT:OPT_OSC_BIT]);
         end
         causeFlags_reg <= causeNext;
      end
   end

   // core and usb clocks: core toggles every third clock, so both phases match
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         corePhase_reg <= 2'h0;
         coreClock <= 1'b0;
         usbPhase_reg <= 3'h0;
         usbClock <= 1'b0;
      end else begin
         corePhase_reg <= coreToggle ? 2'h0 : corePhase_reg + 2'h1; // [R1] [R3]
         coreClock <= coreToggle ? !coreClock : coreClock; // [R1] [R3]
         usbPhase_reg <= usbToggle ? 3'h0 : usbPhase_reg + 3'h1; // [R2]
         usbClock <= usbToggle ? !usbClock : usbClock; // [R2]
      end
   end

   slow_clock_divider slowDivider (
      .clock(clock),
      .sys_rst(sys_rst),
      .coreToggle(coreToggle),
      .dividerSelect(miscReg_reg.slowDividerSelect),
      .slowClock(slowClock)
   );

   // clock out on port b0 and the open-drain reset pin
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         portB0Out <= 1'b0;
         portB0Oe <= 1'b0;
         resetPinOut <= 1'b0;
         resetPinOe <= 1'b0;
         driveHist_reg <= '0;
         watchdogHold_reg <= 1'b0;
      end else begin
         portB0Out <= miscReg_reg.clockOutEnable && coreClock; // [R5]
         portB0Oe <= miscReg_reg.clockOutEnable; // [R5]
         resetPinOut <= 1'b0;
         resetPinOe <= driveNext; // [R9] [R11]
         driveHist_reg <= {driveHist_reg[PIN_BLANK_CLOCKS-2:0], resetPinOe};
         // a watchdog pulse keeps the pin low until the start-up delay ends
         if (watchdogReset) begin
            watchdogHold_reg <= 1'b1; // [R11]
         end else if (state_reg == ST_WAIT && waitDone) begin
            watchdogHold_reg <= 1'b0;
         end
      end
   end

   // sequencer registers and vector fetch, high byte at the lower address
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg <= ST_HOLD;
         waitCount_reg <= 12'h000;
         coreReset <= 1'b1;
         memAddr <= 16'h0000;
         memRead <= 1'b0;
         vectorHigh_reg <= 8'h00;
         pcValue <= 16'h0000;
         pcLoad <= 1'b0;
      end else begin
         state_reg <= state_next;
         waitCount_reg <= (state_reg == ST_WAIT && !anyReset) ? waitCount_reg + 12'h001 : 12'h000;
         coreReset <= (state_next != ST_RUN);
         memRead <= (state_next == ST_FETCH_HI) || (state_next == ST_FETCH_LO);
         memAddr <= (state_next == ST_FETCH_LO) ? VECTOR_LOW_ADDR : VECTOR_HIGH_ADDR; // [R7]
         if (state_reg == ST_FETCH_HI) begin
            vectorHigh_reg <= memData;
         end
         pcLoad <= (state_reg == ST_FETCH_LO) && !anyReset; // [R7]
         if (state_reg == ST_FETCH_LO) begin
            pcValue <= {vectorHigh_reg, memData}; // [R7]
         end
      end
   end

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_core_high_phase: assert property ($rose(coreClock) |-> coreClock[*3] ##1 !coreClock) // [R1]
      else $error("core clock high phase not three clocks");
   a_core_low_phase: assert property ($fell(coreClock) |-> !coreClock[*3] ##1 coreClock) // [R3]
      else $error("core clock low phase not three clocks");
   a_usb_fast_half: assert property (($rose(usbClock) && optionReg_reg.oscFreqSelect
      && !writeOption) |-> usbClock[*4]) // [R2]
      else $error("usb clock half period wrong in 12 MHz mode");
   a_clock_out_pin: assert property (miscReg_reg.clockOutEnable && !writeMisc
      |=> portB0Oe && portB0Out == $past(coreClock)) // [R5]
      else $error("port b0 does not follow core clock");
   a_lvd_pin_drive: assert property (lvdActive |=> resetPinOe) // [R9]
      else $error("reset pin not driven during low voltage");
   a_lvd_ignored: assert property (lvdSync_reg && optionReg_reg.undervoltageDetectorDisable
      && !watchdogActive |=> !resetPinOe) // [R10]
      else $error("disabled detector still drives reset");
   a_wdg_pin_drive: assert property (watchdogReset |=> resetPinOe ##1 resetPinOe) // [R11]
      else $error("watchdog reset did not pull reset pin");
   a_startup_delay: assert property ($rose(state_reg == ST_FETCH_HI)
      |-> $past(waitCount_reg) == WAIT_LAST) // [R8]
      else $error("vector fetch before start-up delay");
   a_vector_load: assert property (state_reg == ST_FETCH_HI && !anyReset ##1 !anyReset
      |=> pcLoad && pcValue == {$past(memData, 2), $past(memData)} && !coreReset) // [R7]
      else $error("program counter not loaded from vector");
   a_pin_reset: assert property (pinRequest |=> state_reg == ST_HOLD && coreReset) // [R13]
      else $error("external pin request did not reset");

   // usb half period in 6 MHz mode; a mode change may only lengthen the phase
   a_usb_slow_half: assert property (($rose(usbClock) && !optionReg_reg.oscFreqSelect
      && !writeOption) |-> usbClock[*2]) // [R2]
      else $error("usb clock half period wrong in 6 MHz mode");

   // clock output off: the port is released and shows no clock
   a_clock_out_off: assert property (!miscReg_reg.clockOutEnable && !writeMisc
      |=> !portB0Oe && !portB0Out) // [R5]
      else $error("port b0 driven while clock output disabled");

   // a watchdog request holds the core in reset at once
   a_wdg_core_hold: assert property (watchdogReset |=> coreReset) // [R6]
      else $error("watchdog request did not hold the core");

   // no start-up count runs while the oscillator is not seen active
   a_osc_hold: assert property (!oscSync_reg |=> state_reg == ST_HOLD && coreReset) // [R8]
      else $error("sequencer left hold without oscillator");

   // the bus answer is a single-cycle pulse, an error only with it
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready stood longer than one cycle");
   a_error_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");

   // while the pin is driven, its low level is no request
   a_pin_blanked: assert property (resetPinOe |-> !pinRequest) // [R13]
      else $error("own pin drive taken as external request");

   c_pc_loaded: cover property (pcLoad);
   c_watchdog_reset: cover property (watchdogReset ##1 resetPinOe);
   c_pin_reset: cover property (pinRequest);
   c_lvd_reset: cover property (lvdActive ##1 resetPinOe);
   c_lvd_disabled: cover property (lvdSync_reg && optionReg_reg.undervoltageDetectorDisable);
endmodule // clock_divider_reset_control

// ---- test/reset_partner.sv ----
// partner model: oscillator source, open-drain reset circuit with pull-up, vector memory
`timescale 1ns/1ps
module reset_partner #(
   parameter logic [15:0] VECTOR = 16'h5AC3,
   parameter int EXT_LOW_CLOCKS = 12
) (
   input wire logic clock,
   input wire logic oscOn,
   input wire logic extStart,
   input wire logic resetPinOe,
   input wire logic memRead,
   input wire logic [15:0] memAddr,
   output logic oscActive,
   output logic resetPinIn_n,
   output logic [7:0] memData
);
   import clock_reset_pkg::*;
   logic [4:0] extCount_reg = 5'h00;
   logic [7:0] noise_reg = 8'h00;

   // the external circuit holds the pin low for two core cycles, above the minimum
   always_ff @(posedge clock) begin
      if (extStart) begin
         extCount_reg <= 5'(EXT_LOW_CLOCKS);
      end else if (extCount_reg != 5'h00) begin
         extCount_reg <= extCount_reg - 5'h01;
      end
      noise_reg <= noise_reg + 8'h5B;
   end

   // wired-and with pull-up; idle memory bus shows a changing pattern, not stale data
   assign oscActive = oscOn;
   assign resetPinIn_n = !(resetPinOe || extCount_reg != 5'h00);
   assign memData = !memRead ? noise_reg :
      (memAddr == VECTOR_HIGH_ADDR) ? VECTOR[15:8] :
      (memAddr == VECTOR_LOW_ADDR) ? VECTOR[7:0] : ~noise_reg;
endmodule // reset_partner

// ---- test/test_clock_divider_reset_control.sv ----
// self-checking bench for the clock divider and reset control block
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin nErrors++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module test_clock_divider_reset_control;
   import clock_reset_pkg::*;
   localparam logic [15:0] VECTOR = 16'h5AC3;
   logic clock, sys_rst, oscOn, extStart, lowVoltage, watchdogReset, memRead, pcLoad;
   logic pready, pslverr, resetPinOut, resetPinOe, resetPinIn_n, oscActive, rdErr;
   logic coreClock, slowClock, usbClock, portB0Out, portB0Oe, coreReset;
   logic [31:0] prdata, rdData;
   logic [15:0] memAddr, pcValue;
   logic [7:0] memData;
   apb_req_type apbReq;
   int nErrors = 0;
   int checkCount = 0;

   // instances: the partner answers the vector fetch and shares the reset pin
   clock_divider_reset_control i_dut (.clock(clock), .sys_rst(sys_rst), .apbReq(apbReq),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscActive(oscActive),
      .lowVoltage(lowVoltage), .watchdogReset(watchdogReset), .resetPinIn_n(resetPinIn_n),
      .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .coreClock(coreClock),
      .slowClock(slowClock), .usbClock(usbClock), .portB0Out(portB0Out),
      .portB0Oe(portB0Oe), .coreReset(coreReset), .memAddr(memAddr), .memRead(memRead),
      .memData(memData), .pcValue(pcValue), .pcLoad(pcLoad));
   reset_partner #(.VECTOR(VECTOR)) i_partner (.clock(clock), .oscOn(oscOn),
      .extStart(extStart), .resetPinOe(resetPinOe), .memRead(memRead), .memAddr(memAddr),
      .oscActive(oscActive), .resetPinIn_n(resetPinIn_n), .memData(memData));

   always #12.5 clock = ~clock;

   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask

   // one apb transfer; entered just after a rising edge, holds until pready is sampled
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clock);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rdData = prdata;
      rdErr = pslverr;
      apbReq <= '0;
      @(posedge clock);
   endtask

   task automatic waitRun(output int n);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pcLoad !== 1'b1 && n < 4000);
   endtask

   function automatic logic sig(input int s);
      return (s == 0) ? coreClock : (s == 1) ? usbClock : slowClock;
   endfunction

   // measures a full high and low phase twice, so a change of divider settles first
   task automatic halves(input int s, output int h, output int l);
      int k;
      k = 0;
      repeat (2) begin
         h = 0;
         l = 0;
         while (sig(s) !== 1'b0 && k < 400) begin step(1); k++; end
         while (sig(s) !== 1'b1 && k < 400) begin step(1); k++; end
         while (sig(s) === 1'b1 && k < 400) begin step(1); k++; h++; end
         while (sig(s) === 1'b0 && k < 400) begin step(1); k++; l++; end
      end
   endtask

   task automatic tStartup();
      int n;
      waitRun(n);
      `CHECK("startup delay", 1'b1, n >= STARTUP_CLOCKS && n <= STARTUP_CLOCKS + 10)
      `CHECK("pc vector", VECTOR, pcValue)
      step(1);
      `CHECK("core running", 1'b0, coreReset)
      apb(1'b0, MISC_OFFSET, DATA_ZERO);
      `CHECK("misc reset", DATA_ZERO, rdData)
      apb(1'b0, 8'h0C, DATA_ZERO);
      `CHECK("unmapped err", 1'b1, rdErr)
      $display("test startup done");
   endtask

   task automatic tClocks();
      int h, l, s;
      logic prev;
      halves(0, h, l);
      `CHECK("core high", CORE_HALF_CLOCKS, h)
      `CHECK("core low", CORE_HALF_CLOCKS, l)
      halves(1, h, l);
      `CHECK("usb half", USB_HALF_SLOW_OSC, h)
      apb(1'b1, OPTION_OFFSET, 32'h0000_0001);
      halves(1, h, l);
      `CHECK("usb half fast", USB_HALF_FAST_OSC, l)
      halves(0, h, l);
      `CHECK("core fast option", CORE_HALF_CLOCKS, h)
      // switch back during a low usb phase so no high phase is cut short
      while (usbClock !== 1'b0) step(1);
      apb(1'b1, OPTION_OFFSET, DATA_ZERO);
      for (s = 0; s < 4; s++) begin
         apb(1'b1, MISC_OFFSET, 32'(s) << MISC_SLOW_LSB);
         halves(2, h, l);
         `CHECK("slow half", CORE_HALF_CLOCKS << s, h)
      end
      // reserved bits must read back as zero
      apb(1'b1, MISC_OFFSET, 32'hFFFF_FFFF);
      apb(1'b0, MISC_OFFSET, DATA_ZERO);
      `CHECK("misc readback", 32'h0000_0007, rdData)
      step(2);
      `CHECK("b0 enabled", 1'b1, portB0Oe)
      prev = coreClock;
      repeat (12) begin
         step(1);
         `CHECK("b0 clock", prev, portB0Out)
         prev = coreClock;
      end
      apb(1'b1, MISC_OFFSET, DATA_ZERO);
      step(2);
      `CHECK("b0 disabled", 1'b0, portB0Oe)
      $display("test clocks done");
   endtask

   task automatic tLvd();
      int n;
      lowVoltage <= 1'b1;
      step(5);
      `CHECK("lvd core", 1'b1, coreReset)
      `CHECK("lvd pin drive", 1'b1, resetPinOe)
      `CHECK("lvd pin low", 1'b0, resetPinIn_n)
      apb(1'b0, STATUS_OFFSET, DATA_ZERO);
      `CHECK("lvd cause", 1'b1, rdData[STAT_LVD_BIT])
      lowVoltage <= 1'b0;
      waitRun(n);
      `CHECK("lvd pin free", 1'b0, resetPinOe)
      apb(1'b1, OPTION_OFFSET, 32'h0000_0002);
      lowVoltage <= 1'b1;
      step(8);
      `CHECK("lvd ignored", 1'b0, coreReset)
      `CHECK("lvd pin ignored", 1'b0, resetPinOe)
      lowVoltage <= 1'b0;
      apb(1'b1, OPTION_OFFSET, DATA_ZERO);
      $display("test low voltage done");
   endtask

   task automatic tWdg();
      int n;
      watchdogReset <= 1'b1;
      step(1);
      watchdogReset <= 1'b0;
      step(3);
      `CHECK("wdg core", 1'b1, coreReset)
      `CHECK("wdg pin drive", 1'b1, resetPinOe)
      apb(1'b0, STATUS_OFFSET, DATA_ZERO);
      `CHECK("wdg cause", 1'b1, rdData[STAT_WDG_BIT])
      waitRun(n);
      `CHECK("wdg run", 1'b1, pcLoad)
      $display("test watchdog done");
   endtask

   task automatic tPin();
      int n;
      extStart <= 1'b1;
      step(1);
      extStart <= 1'b0;
      step(6);
      `CHECK("pin core", 1'b1, coreReset)
      apb(1'b0, STATUS_OFFSET, DATA_ZERO);
      `CHECK("pin cause", 1'b1, rdData[STAT_PIN_BIT])
      waitRun(n);
      `CHECK("pin run", VECTOR, pcValue)
      $display("test pin done");
   endtask

   task automatic tOsc();
      int n;
      oscOn <= 1'b0;
      step(4);
      `CHECK("osc core", 1'b1, coreReset)
      oscOn <= 1'b1;
      waitRun(n);
      `CHECK("osc delay", 1'b1, n >= STARTUP_CLOCKS && n <= STARTUP_CLOCKS + 10)
      $display("test oscillator done");
   endtask

   task automatic printVerdict();
      $display("checks %0d mismatches %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // main sequence; every source ends with a full start-up before the next test
   initial begin
      clock = 1'b0;
      sys_rst = 1'b1;
      apbReq = '0;
      oscOn = 1'b1;
      extStart = 1'b0;
      lowVoltage = 1'b0;
      watchdogReset = 1'b0;
      step(3);
      sys_rst <= 1'b0;
      tStartup();
      tClocks();
      tLvd();
      tWdg();
      tPin();
      tOsc();
      printVerdict();
   end

   // hang guard, well above six start-up delays
   initial begin
      step(40000);
      nErrors++;
      printVerdict();
   end
endmodule // test_clock_divider_reset_control
